// ===== src/ptlb_pkg.sv
// Shared constants and types of the PCI target to local bus path
package ptlb_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_IMG0_CTL = 8'h00;
	localparam logic [7:0] OFS_IMG0_ADR = 8'h04;
	localparam logic [7:0] OFS_IMG1_CTL = 8'h08;
	localparam logic [7:0] OFS_IMG1_ADR = 8'h0C;
	localparam logic [7:0] OFS_MISC     = 8'h10;
	localparam logic [7:0] OFS_MISC2    = 8'h14;
	localparam logic [7:0] OFS_ISTAT    = 8'h18;
	localparam logic [7:0] OFS_IEN      = 8'h1C;

	// ==========================================================
	// Field positions
	localparam int CTL_EN    = 31;
	localparam int CTL_IO    = 30;
	localparam int CTL_BURST = 28;
	localparam int CTL_SIZE  = 24;
	localparam int CTL_WIDTH = 22;
	localparam int CTL_TC    = 16;
	localparam int ADR_BASE  = 16;
	localparam int MISC2_ODD = 0;
	localparam int ISTAT_PE  = 0;
	localparam int IEN_EN    = 0;
	localparam int IEN_ROUTE = 1;

	// ==========================================================
	// Reset values and masks
	localparam logic [31:0] CTL_RST  = 32'h0000_0000;
	localparam logic [31:0] ADR_RST  = 32'h0000_0000;
	localparam logic [31:0] CTL_MASK = 32'hDFCF_0000;

	// ==========================================================
	// PCI commands
	localparam logic [3:0] CMD_IO_RD  = 4'h2;
	localparam logic [3:0] CMD_IO_WR  = 4'h3;
	localparam logic [3:0] CMD_MEM_RD = 4'h6;
	localparam logic [3:0] CMD_MEM_WR = 4'h7;
	localparam logic [3:0] CMD_CFG_RD = 4'hA;
	localparam logic [3:0] CMD_CFG_WR = 4'hB;
	localparam logic [3:0] CMD_MRM    = 4'hC;
	localparam logic [3:0] CMD_MRL    = 4'hE;
	localparam logic [3:0] CMD_MWI    = 4'hF;

	// ==========================================================
	// Sizes and counts
	localparam int QUEUE_BYTES = 256;
	localparam int QUEUE_WORDS = QUEUE_BYTES / 4;
	localparam int BURST_BEATS = 4;
	localparam int STRAP_WAIT  = 2;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		STYLE_A = 2'b00,
		STYLE_B = 2'b01,
		STYLE_C = 2'b10
	} ptlb_style_t;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] data;
		logic [3:0]  be;
		logic [1:0]  width;
		logic [3:0]  tc;
	} ptlb_wr_entry_t;

endpackage

// ===== src/ptlb_img_decode.sv
// Address decode and translation of one PCI target image
`timescale 1ns/100ps
module ptlb_img_decode (
	input  wire logic [31:0] ctl,
	input  wire logic [31:0] adr,
	input  wire logic [31:0] pci_addr,
	input  wire logic        is_io,
	input  wire logic        is_mem,
	output logic             hit,
	output logic [31:0]      lb_addr
);
	logic [15:0] cmp_mask;
	logic [15:0] base;
	logic [15:0] xlat;
	logic        space_ok;

	assign base     = adr[31:ptlb_pkg::ADR_BASE];
	assign xlat     = adr[15:0];
	assign cmp_mask = 16'hFFFF << ctl[ptlb_pkg::CTL_SIZE +: 4];
	assign space_ok = ctl[ptlb_pkg::CTL_IO] ? is_io : is_mem;
	assign hit      = ctl[ptlb_pkg::CTL_EN] & space_ok &
	                  ~|((pci_addr[31:16] ^ base) & cmp_mask);
	assign lb_addr  = {(xlat & cmp_mask) | (pci_addr[31:16] & ~cmp_mask),
	                   pci_addr[15:0]};
endmodule

// ===== src/ptlb_target_path.sv
// PCI target channel front end replaying accesses on the local bus
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
module ptlb_target_path #(
	parameter int WQ_WORDS = ptlb_pkg::QUEUE_WORDS,
	parameter int RQ_WORDS = ptlb_pkg::QUEUE_WORDS
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        pci_req,
	input  wire logic [31:0] pci_addr,
	input  wire logic [3:0]  pci_cmd,
	input  wire logic [3:0]  pci_be,
	input  wire logic [31:0] pci_wdata,
	output logic             pci_devsel_q,
	output logic             pci_ack_q,
	output logic [31:0]      pci_rdata_q,
	output logic             pci_int_n_q,
	output logic             lb_req_q,
	output logic             lb_wr_q,
	output logic             lb_burst_q,
	output logic [31:0]      lb_addr_q,
	output logic [31:0]      lb_wdata_q,
	output logic [3:0]       lb_be_q,
	output logic [3:0]       local_byte_parity_q,
	output logic [1:0]       lb_width_q,
	output logic [3:0]       lb_tc_q,
	input  wire logic        lb_ack,
	input  wire logic [31:0] lb_rdata,
	input  wire logic [3:0]  lb_rpar,
	input  wire logic        burst_in_progress_strap,
	input  wire logic        size_strap_bit,
	output logic             local_irq_out_n_q
);
	localparam int WQ_AW = $clog2(WQ_WORDS);
	localparam int RQ_AW = $clog2(RQ_WORDS);

	if (WQ_WORDS < 2 || RQ_WORDS < ptlb_pkg::BURST_BEATS ||
	    (WQ_WORDS & (WQ_WORDS - 1)) != 0 ||
	    (RQ_WORDS & (RQ_WORDS - 1)) != 0) begin : g_chk
		$error("Queue depths must be powers of two, read queue >= 4");
	end

	// ==========================================================
	// Parity helper
	function automatic logic [3:0] lane_par(input logic [31:0] d,
	                                       input logic odd);
		logic [3:0] p;
		p = 4'h0;
		for (int i = 0; i < 4; i++) begin
			p[i] = ^d[8*i +: 8] ^ odd;
		end
		return p;
	endfunction

	// ==========================================================
	// Strap capture
	logic [1:0] strap_s1_q;
	logic [1:0] strap_s2_q;
	logic [1:0] strap_cnt_q;
	logic       strap_done_q;
	logic [3:0] role_q;
	logic [1:0] master_style;
	logic [1:0] slave_allow;

	// 00/01 -> A, 10 -> C, 11 -> B
	assign master_style = !strap_s2_q[1] ? ptlb_pkg::STYLE_A :
	                      strap_s2_q[0] ? ptlb_pkg::STYLE_B :
	                      ptlb_pkg::STYLE_C;
	// Bit 1 style B allowed, bit 0 style C allowed, A always
	assign slave_allow  = strap_s2_q[0] ? 2'b10 : 2'b01;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_s1_q   <= 2'b00;
			strap_s2_q   <= 2'b00;
			strap_cnt_q  <= 2'b00;
			strap_done_q <= 1'b0;
			role_q       <= 4'h0;
		end else begin
			strap_s1_q <= {burst_in_progress_strap, size_strap_bit};
			strap_s2_q <= strap_s1_q;
			if (!strap_done_q) begin
				strap_cnt_q <= strap_cnt_q + 2'd1;
			end
			if (!strap_done_q && strap_cnt_q == 2'(ptlb_pkg::STRAP_WAIT)) begin
				strap_done_q <= 1'b1;
				role_q       <= {slave_allow, master_style};
			end
		end
	end

	// ==========================================================
	// Register file
	logic [31:0] img_ctl_q [2];
	logic [31:0] img_adr_q [2];
	logic        par_odd_q;
	logic [1:0]  ien_q;
	logic        perr_q;
	logic        pready_q;
	logic        pslverr_q;
	logic [31:0] prdata_q;
	logic        apb_setup;
	logic        apb_wr;
	logic        addr_ok;
	logic [31:0] rd_mux;
	logic        perr_hit;
	logic        perr_w1c;
	logic        irq_on;

	assign apb_setup = psel & ~penable;
	assign apb_wr    = psel & penable & pready_q & pwrite & ~pslverr_q;
	assign addr_ok   = paddr[1:0] == 2'b00 && paddr <= ptlb_pkg::OFS_IEN;
	assign perr_w1c  = apb_wr && paddr == ptlb_pkg::OFS_ISTAT &&
	                   pwdata[ptlb_pkg::ISTAT_PE];
	assign irq_on    = perr_q & ien_q[ptlb_pkg::IEN_EN];

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (paddr)
			ptlb_pkg::OFS_IMG0_CTL: rd_mux = img_ctl_q[0];
			ptlb_pkg::OFS_IMG0_ADR: rd_mux = img_adr_q[0];
			ptlb_pkg::OFS_IMG1_CTL: rd_mux = img_ctl_q[1];
			ptlb_pkg::OFS_IMG1_ADR: rd_mux = img_adr_q[1];
			ptlb_pkg::OFS_MISC:     rd_mux = {28'h000_0000, role_q};
			ptlb_pkg::OFS_MISC2:    rd_mux = {31'h0000_0000, par_odd_q};
			ptlb_pkg::OFS_ISTAT:    rd_mux = {31'h0000_0000, perr_q};
			ptlb_pkg::OFS_IEN:      rd_mux = {30'h0000_0000, ien_q};
			default:                rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= apb_setup;
			pslverr_q <= apb_setup & ~addr_ok;
			if (apb_setup) begin
				prdata_q <= (addr_ok && !pwrite) ? rd_mux : 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			img_ctl_q <= '{ptlb_pkg::CTL_RST, ptlb_pkg::CTL_RST};
			img_adr_q <= '{ptlb_pkg::ADR_RST, ptlb_pkg::ADR_RST};
			par_odd_q <= 1'b0;
			ien_q     <= 2'b00;
		end else if (apb_wr) begin
			case (paddr)
				ptlb_pkg::OFS_IMG0_CTL: img_ctl_q[0] <= pwdata & ptlb_pkg::CTL_MASK;
				ptlb_pkg::OFS_IMG0_ADR: img_adr_q[0] <= pwdata;
				ptlb_pkg::OFS_IMG1_CTL: img_ctl_q[1] <= pwdata & ptlb_pkg::CTL_MASK;
				ptlb_pkg::OFS_IMG1_ADR: img_adr_q[1] <= pwdata;
				ptlb_pkg::OFS_MISC2:    par_odd_q <= pwdata[ptlb_pkg::MISC2_ODD];
				ptlb_pkg::OFS_IEN:      ien_q <= pwdata[1:0];
				default:                ;
			endcase
		end
	end

	// Set wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			perr_q            <= 1'b0;
			pci_int_n_q       <= 1'b1;
			local_irq_out_n_q <= 1'b1;
		end else begin
			perr_q            <= perr_hit | (perr_q & ~perr_w1c);
			pci_int_n_q       <= ~(irq_on & ~ien_q[ptlb_pkg::IEN_ROUTE]);
			local_irq_out_n_q <= ~(irq_on & ien_q[ptlb_pkg::IEN_ROUTE]);
		end
	end

	assign pready  = pready_q;
	assign pslverr = pslverr_q;
	assign prdata  = prdata_q;

	// ==========================================================
	// Command and image decode
	// Snoop and lock sideband pins do not exist on this port
	logic        is_io;
	logic        is_mem;
	logic        is_cfg0;
	logic        is_write;
	logic        claim;
	logic [1:0]  img_hit;
	logic [31:0] img_lb_addr [2];
	logic        use1;
	logic [31:0] sel_ctl;
	logic [31:0] sel_lb_addr;

	assign is_io    = pci_cmd == ptlb_pkg::CMD_IO_RD ||
	                  pci_cmd == ptlb_pkg::CMD_IO_WR;
	assign is_mem   = pci_cmd == ptlb_pkg::CMD_MEM_RD ||
	                  pci_cmd == ptlb_pkg::CMD_MEM_WR ||
	                  pci_cmd == ptlb_pkg::CMD_MRM ||
	                  pci_cmd == ptlb_pkg::CMD_MRL ||
	                  pci_cmd == ptlb_pkg::CMD_MWI;
	assign is_cfg0  = (pci_cmd == ptlb_pkg::CMD_CFG_RD ||
	                   pci_cmd == ptlb_pkg::CMD_CFG_WR) &&
	                  pci_addr[1:0] == 2'b00;
	assign is_write = pci_cmd == ptlb_pkg::CMD_IO_WR ||
	                  pci_cmd == ptlb_pkg::CMD_MEM_WR ||
	                  pci_cmd == ptlb_pkg::CMD_MWI;

	for (genvar g = 0; g < 2; g++) begin : g_img
		ptlb_img_decode u_dec (
			.ctl      (img_ctl_q[g]),
			.adr      (img_adr_q[g]),
			.pci_addr (pci_addr),
			.is_io    (is_io),
			.is_mem   (is_mem),
			.hit      (img_hit[g]),
			.lb_addr  (img_lb_addr[g])
		);
	end

	assign use1        = ~img_hit[0];
	assign sel_ctl     = use1 ? img_ctl_q[1] : img_ctl_q[0];
	assign sel_lb_addr = use1 ? img_lb_addr[1] : img_lb_addr[0];
	assign claim       = |img_hit | is_cfg0;

	// ==========================================================
	// Target state machine
	typedef enum logic [6:0] {
		ST_IDLE  = 7'b000_0001,
		ST_DEC   = 7'b000_0010,
		ST_WR    = 7'b000_0100,
		ST_RD    = 7'b000_1000,
		ST_FETCH = 7'b001_0000,
		ST_ACK   = 7'b010_0000,
		ST_IGN   = 7'b100_0000
	} ptlb_state_t;

	ptlb_state_t state_q;
	ptlb_state_t state_d;
	logic        ack_d;
	logic [31:0] rdata_d;
	logic        wq_push;
	logic        rq_pop;
	logic        fetch_go;
	logic        rq_hit;
	logic        wq_full;
	logic        wq_empty;
	logic        lb_done;
	logic [31:0] rq_head;

	always_comb begin
		state_d  = state_q;
		ack_d    = 1'b0;
		rdata_d  = pci_rdata_q;
		wq_push  = 1'b0;
		rq_pop   = 1'b0;
		fetch_go = 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (pci_req && strap_done_q) begin
					state_d = ST_DEC;
				end
			end
			ST_DEC: begin
				if (!claim) begin
					state_d = ST_IGN;
				end else if (is_cfg0) begin
					// Config space is answered here, never forwarded
					state_d = ST_ACK;
					ack_d   = 1'b1;
					rdata_d = 32'h0000_0000;
				end else begin
					state_d = is_write ? ST_WR : ST_RD;
				end
			end
			ST_WR: begin
				if (!wq_full) begin
					wq_push = 1'b1;
					ack_d   = 1'b1;
					state_d = ST_ACK;
				end
			end
			ST_RD: begin
				// Reads wait until posted writes have drained
				if (wq_empty && !lb_req_q) begin
					if (rq_hit) begin
						rq_pop  = 1'b1;
						ack_d   = 1'b1;
						rdata_d = rq_head;
						state_d = ST_ACK;
					end else begin
						fetch_go = 1'b1;
						state_d  = ST_FETCH;
					end
				end
			end
			ST_FETCH: begin
				if (lb_done) begin
					state_d = ST_RD;
				end
			end
			ST_ACK:  state_d = ST_IDLE;
			ST_IGN: begin
				if (!pci_req) begin
					state_d = ST_IDLE;
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q      <= ST_IDLE;
			pci_ack_q    <= 1'b0;
			pci_devsel_q <= 1'b0;
			pci_rdata_q  <= 32'h0000_0000;
		end else begin
			state_q      <= state_d;
			pci_ack_q    <= ack_d;
			pci_devsel_q <= state_d inside {ST_WR, ST_RD, ST_FETCH, ST_ACK};
			pci_rdata_q  <= rdata_d;
		end
	end

	// ==========================================================
	// Posted write queue
	ptlb_pkg::ptlb_wr_entry_t wq_mem [WQ_WORDS];
	ptlb_pkg::ptlb_wr_entry_t wq_in;
	ptlb_pkg::ptlb_wr_entry_t wq_head;
	logic [WQ_AW-1:0] wq_wp_q;
	logic [WQ_AW-1:0] wq_rp_q;
	logic [WQ_AW:0]   wq_cnt_q;
	logic             wq_pop;

	assign wq_in    = '{addr: sel_lb_addr, data: pci_wdata, be: pci_be,
	                    width: sel_ctl[ptlb_pkg::CTL_WIDTH +: 2],
	                    tc: sel_ctl[ptlb_pkg::CTL_TC +: 4]};
	assign wq_head  = wq_mem[wq_rp_q];
	assign wq_full  = wq_cnt_q == (WQ_AW+1)'(WQ_WORDS);
	assign wq_empty = wq_cnt_q == '0;
	assign wq_pop   = lb_req_q & lb_wr_q & lb_ack;

	always_ff @(posedge pclk) begin
		if (wq_push) begin
			wq_mem[wq_wp_q] <= wq_in;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wq_wp_q  <= '0;
			wq_rp_q  <= '0;
			wq_cnt_q <= '0;
		end else begin
			wq_wp_q  <= wq_wp_q + WQ_AW'(wq_push);
			wq_rp_q  <= wq_rp_q + WQ_AW'(wq_pop);
			wq_cnt_q <= wq_cnt_q + (WQ_AW+1)'(wq_push) - (WQ_AW+1)'(wq_pop);
		end
	end

	// ==========================================================
	// Read return queue
	logic [31:0]      rq_mem [RQ_WORDS];
	logic [RQ_AW-1:0] rq_wp_q;
	logic [RQ_AW-1:0] rq_rp_q;
	logic [RQ_AW:0]   rq_cnt_q;
	logic [31:0]      rq_tag_q;
	logic             rq_push;
	logic             rq_flush;

	// Any posted write makes held read data stale
	assign rq_flush = fetch_go | wq_push;
	assign rq_push  = lb_req_q & ~lb_wr_q & lb_ack;
	assign rq_head  = rq_mem[rq_rp_q];
	assign rq_hit   = rq_cnt_q != '0 && rq_tag_q == pci_addr;

	always_ff @(posedge pclk) begin
		if (rq_push) begin
			rq_mem[rq_wp_q] <= lb_rdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rq_wp_q  <= '0;
			rq_rp_q  <= '0;
			rq_cnt_q <= '0;
			rq_tag_q <= 32'h0000_0000;
		end else if (rq_flush) begin
			rq_wp_q  <= '0;
			rq_rp_q  <= '0;
			rq_cnt_q <= '0;
			rq_tag_q <= pci_addr;
		end else begin
			rq_wp_q  <= rq_wp_q + RQ_AW'(rq_push);
			rq_rp_q  <= rq_rp_q + RQ_AW'(rq_pop);
			rq_cnt_q <= rq_cnt_q + (RQ_AW+1)'(rq_push) - (RQ_AW+1)'(rq_pop);
			if (rq_pop) begin
				rq_tag_q <= rq_tag_q + 32'h0000_0004;
			end
		end
	end

	// ==========================================================
	// Local bus master
	logic [2:0] lb_beats_q;
	logic       start_wr;
	logic       use_burst;

	assign start_wr  = ~lb_req_q & ~wq_empty & ~fetch_go &
	                   state_q != ST_FETCH;
	assign use_burst = role_q[1:0] == ptlb_pkg::STYLE_B &&
	                   sel_ctl[ptlb_pkg::CTL_BURST];
	assign lb_done   = lb_req_q & ~lb_wr_q & lb_ack & lb_beats_q == 3'd1;
	// Parity result feeds status only, never the handshake
	assign perr_hit  = rq_push && |((lb_rpar ^ lane_par(lb_rdata, par_odd_q))
	                   & lb_be_q);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lb_req_q            <= 1'b0;
			lb_wr_q             <= 1'b0;
			lb_burst_q          <= 1'b0;
			lb_addr_q           <= 32'h0000_0000;
			lb_wdata_q          <= 32'h0000_0000;
			lb_be_q             <= 4'h0;
			local_byte_parity_q <= 4'h0;
			lb_width_q          <= 2'b00;
			lb_tc_q             <= 4'h0;
			lb_beats_q          <= 3'd0;
		end else if (fetch_go) begin
			lb_req_q   <= 1'b1;
			lb_wr_q    <= 1'b0;
			lb_burst_q <= use_burst;
			lb_addr_q  <= sel_lb_addr;
			lb_be_q    <= use_burst ? 4'hF : pci_be;
			lb_width_q <= sel_ctl[ptlb_pkg::CTL_WIDTH +: 2];
			lb_tc_q    <= sel_ctl[ptlb_pkg::CTL_TC +: 4];
			lb_beats_q <= use_burst ? 3'(ptlb_pkg::BURST_BEATS) : 3'd1;
		end else if (start_wr) begin
			lb_req_q            <= 1'b1;
			lb_wr_q             <= 1'b1;
			lb_burst_q          <= 1'b0;
			lb_addr_q           <= wq_head.addr;
			lb_wdata_q          <= wq_head.data;
			lb_be_q             <= wq_head.be;
			local_byte_parity_q <= lane_par(wq_head.data, par_odd_q);
			lb_width_q          <= wq_head.width;
			lb_tc_q             <= wq_head.tc;
			lb_beats_q          <= 3'd1;
		end else if (lb_req_q && lb_ack) begin
			lb_beats_q <= lb_beats_q - 3'd1;
			if (lb_beats_q == 3'd1) begin
				lb_req_q   <= 1'b0;
				lb_burst_q <= 1'b0;
			end
		end
	end

endmodule

// ===== tb/ptlb_target_path_chk.sv
// Port-level assertions of the target path
`timescale 1ns/100ps
module ptlb_chk #(
	parameter int WQ_WORDS = 64,
	parameter int RQ_WORDS = 64
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pci_req,
	input wire logic [31:0] pci_addr,
	input wire logic [3:0]  pci_cmd,
	input wire logic        pci_devsel_q,
	input wire logic        pci_ack_q,
	input wire logic        pci_int_n_q,
	input wire logic        lb_req_q,
	input wire logic        lb_wr_q,
	input wire logic        lb_burst_q,
	input wire logic [31:0] lb_addr_q,
	input wire logic [31:0] lb_wdata_q,
	input wire logic [3:0]  local_byte_parity_q,
	input wire logic        lb_ack,
	input wire logic        burst_in_progress_strap,
	input wire logic        size_strap_bit,
	input wire logic        local_irq_out_n_q
);
	// ==========================================================
	// Helper state
	logic       odd_q;
	logic [2:0] age_q;
	wire        misc2_wr = psel && penable && pready && pwrite
		&& paddr == ptlb_pkg::OFS_MISC2;
	wire [3:0]  par_exp = {^lb_wdata_q[31:24], ^lb_wdata_q[23:16],
		^lb_wdata_q[15:8], ^lb_wdata_q[7:0]} ^ {4{odd_q}};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			odd_q <= 1'b0;
			age_q <= 3'd0;
		end else begin
			if (misc2_wr)
				odd_q <= pwdata[ptlb_pkg::MISC2_ODD];
			age_q <= !pci_req ? 3'd0 : age_q + {2'b00, age_q != 3'd7};
		end
	end

	// ==========================================================
	// Assertions
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	property p_dev_speed;
		$rose(pci_devsel_q) |-> age_q inside {3'd2, 3'd3};
	endproperty
	a_dev_speed: assert property (p_dev_speed)
		else $error("devsel late");
	property p_ack_end;
		pci_ack_q |-> pci_devsel_q ##1 (!pci_ack_q && !pci_devsel_q);
	endproperty
	a_ack_end: assert property (p_ack_end)
		else $error("ack without claim");
	property p_cfg1;
		pci_devsel_q |-> !(pci_cmd[3:1] == 3'b101 && pci_addr[1:0] == 2'b01);
	endproperty
	a_cfg1: assert property (p_cfg1)
		else $error("type 1 config claimed");
	property p_wr_par;
		lb_req_q && lb_wr_q |-> local_byte_parity_q == par_exp;
	endproperty
	a_wr_par: assert property (p_wr_par)
		else $error("write parity wrong");
	property p_irq_excl;
		pci_int_n_q || local_irq_out_n_q;
	endproperty
	a_irq_excl: assert property (p_irq_excl)
		else $error("both interrupt outputs low");
	property p_rst_idle;
		$rose(presetn) |-> pci_int_n_q && local_irq_out_n_q && !lb_req_q;
	endproperty
	a_rst_idle: assert property (p_rst_idle)
		else $error("outputs busy after reset");
	property p_burst_b;
		lb_burst_q |-> !lb_wr_q && burst_in_progress_strap && size_strap_bit;
	endproperty
	a_burst_b: assert property (p_burst_b)
		else $error("burst outside style B");
	property p_lb_hold;
		lb_req_q && !lb_ack |=> lb_req_q && $stable(lb_addr_q)
			&& $stable(lb_wdata_q);
	endproperty
	a_lb_hold: assert property (p_lb_hold)
		else $error("local request changed early");
	c_ack: cover property (pci_ack_q);
	c_burst: cover property (lb_burst_q && lb_ack);
	c_irq: cover property (!local_irq_out_n_q);
endmodule

// ===== tb/ptlb_lb_slave.sv
// Local bus slave model: word memory, parity, wait states
`timescale 1ns/100ps
module ptlb_lb_slave (
	input  wire logic        pclk,
	input  wire logic        lb_req_q,
	input  wire logic        lb_wr_q,
	input  wire logic        lb_burst_q,
	input  wire logic [31:0] lb_addr_q,
	input  wire logic [31:0] lb_wdata_q,
	input  wire logic        odd,
	input  wire logic        bad_par,
	input  wire logic [1:0]  slow,
	output logic             lb_ack,
	output logic [31:0]      lb_rdata,
	output logic [3:0]       lb_rpar
);
	logic [31:0] mem [logic [31:0]];
	logic [31:0] a;
	logic [31:0] d;
	int          wt;
	int          beat;
	initial begin
		lb_ack = 1'b0;
		lb_rdata = 32'h0000_0000;
		lb_rpar = 4'h0;
		wt = 0;
		beat = 0;
	end
	always @(posedge pclk) begin
		a = lb_addr_q + 32'(beat * 4);
		d = mem.exists(a) ? mem[a] : 32'h0000_0000;
		if (lb_req_q && !lb_ack && wt >= slow) begin
			if (lb_wr_q)
				mem[a] = lb_wdata_q;
			lb_ack <= 1'b1;
			lb_rdata <= d;
			lb_rpar <= {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]}
				^ {4{odd}} ^ {3'b000, bad_par};
			wt = 0;
			beat = lb_burst_q ? (beat + 1) % 4 : 0;
		end else begin
			// Without ack the bus toggles its data and parity every cycle
			lb_ack <= 1'b0;
			lb_rdata <= ~lb_rdata;
			lb_rpar <= ~lb_rpar;
			wt = lb_req_q ? wt + 1 : 0;
		end
	end
endmodule

// ===== tb/tb.sv
// Self-checking bench of the target path
`timescale 1ns/100ps
module tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        pci_req, pci_devsel_q, pci_ack_q, pci_int_n_q, lb_ack;
	logic        lb_req_q, lb_wr_q, lb_burst_q, local_irq_out_n_q;
	logic        burst_in_progress_strap, size_strap_bit;
	logic        odd, bad_par, ok, err;
	logic [1:0]  slow, lb_width_q;
	logic [3:0]  lb_be_q, lb_tc_q;
	logic [3:0]  pci_cmd, pci_be, local_byte_parity_q, lb_rpar;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, pci_addr, pci_wdata, pci_rdata_q;
	logic [31:0] lb_addr_q, lb_wdata_q, lb_rdata, r, d, a;
	logic [31:0] mdl [logic [31:0]];
	logic [31:0] adq [$];
	logic [3:0]  rdc [3] = '{ptlb_pkg::CMD_MEM_RD, ptlb_pkg::CMD_MRM,
		ptlb_pkg::CMD_MRL};
	logic [3:0]  rc [4] = '{ptlb_pkg::CMD_IO_WR, ptlb_pkg::CMD_MEM_RD,
		ptlb_pkg::CMD_CFG_WR, ptlb_pkg::CMD_CFG_RD};
	logic [31:0] ra [4] = '{32'h1234_0000, 32'h7777_0000, 32'h0000_0001,
		32'h0000_0000};
	int          miscompares, n_checks;

	ptlb_target_path uut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
		.prdata, .pslverr, .pci_req, .pci_addr, .pci_cmd, .pci_be, .pci_wdata,
		.pci_devsel_q, .pci_ack_q, .pci_rdata_q, .pci_int_n_q, .lb_req_q,
		.lb_wr_q, .lb_burst_q, .lb_addr_q, .lb_wdata_q, .lb_be_q,
		.local_byte_parity_q, .lb_width_q, .lb_tc_q, .lb_ack, .lb_rdata,
		.lb_rpar, .burst_in_progress_strap, .size_strap_bit, .local_irq_out_n_q
	);
	ptlb_lb_slave lbs (
		.pclk, .lb_req_q, .lb_wr_q, .lb_burst_q, .lb_addr_q, .lb_wdata_q,
		.odd, .bad_par, .slow, .lb_ack, .lb_rdata, .lb_rpar
	);

	// ==========================================================
	// Tasks
	task automatic chk(input string nm, input logic [31:0] e, g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] ad,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic pci(input logic [3:0] c, input logic [31:0] ad, wd,
		output logic [31:0] rd, output logic k);
		int n;
		@(posedge pclk);
		pci_req <= 1'b1;
		pci_cmd <= c;
		pci_addr <= ad;
		pci_wdata <= wd;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pci_ack_q !== 1'b1 && n < 60);
		k = pci_ack_q;
		rd = pci_rdata_q;
		pci_req <= 1'b0;
	endtask
	task automatic conclude;
		if (miscompares == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ==========================================================
	// Clock, watchdog and sequence
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	initial begin
		#100000;
		miscompares++;
		conclude;
	end
	initial begin
		{presetn, psel, penable, pwrite, pci_req, odd, bad_par} = 7'h00;
		{burst_in_progress_strap, size_strap_bit, slow} = 4'h0;
		{paddr, pwdata, pci_addr, pci_wdata, pci_cmd} = 108'h0;
		pci_be = 4'hF;
		d = $urandom(32'h1b5195a9);
		for (int s = 0; s < 4; s++) begin
			presetn <= 1'b0;
			{burst_in_progress_strap, size_strap_bit} <= s[1:0];
			repeat (2) @(posedge pclk);
			presetn <= 1'b1;
			repeat (4) @(posedge pclk);
			apb(0, ptlb_pkg::OFS_MISC, 0, r);
			chk("role", {28'h0, s[0], !s[0], s[1] ? {!s[0], s[0]} : 2'b00},
				r);
			apb(0, ptlb_pkg::OFS_IMG1_CTL, 0, r);
			chk("ctl_rst", ptlb_pkg::CTL_RST, r);
			apb(0, ptlb_pkg::OFS_ISTAT, 0, r);
			chk("pe_rst", 0, r);
		end
		apb(0, 8'h40, 0, r);
		chk("slverr", 1, err);
		// Disjoint images, one translated
		apb(1, ptlb_pkg::OFS_IMG0_CTL, 32'h9000_0000, r);
		apb(1, ptlb_pkg::OFS_IMG0_ADR, 32'h1234_1234, r);
		apb(1, ptlb_pkg::OFS_IMG1_CTL, 32'h8045_0000, r);
		apb(1, ptlb_pkg::OFS_IMG1_ADR, 32'h4000_5000, r);
		slow <= 2'd3;
		for (int i = 0; i < 8; i++) begin
			a = (i[0] ? 32'h4000_0000 : 32'h1234_0000) + 32'(i * 16);
			d = $urandom;
			pci(i[1] ? ptlb_pkg::CMD_MWI : ptlb_pkg::CMD_MEM_WR, a, d, r, ok);
			chk("post", 1, ok);
			mdl[a] = d;
			adq.push_back(a);
		end
		slow <= 2'd0;
		foreach (adq[i]) begin
			pci(rdc[i % 3], adq[i], 0, r, ok);
			chk("rd", mdl[adq[i]], r);
		end
		chk("lb_attr", {2'b01, 4'h5, 4'hF}, {lb_width_q, lb_tc_q, lb_be_q});
		chk("xlat", mdl[adq[1]], lbs.mem[adq[1] ^ 32'h1000_0000]);
		apb(0, ptlb_pkg::OFS_ISTAT, 0, r);
		chk("even_ok", 0, r);
		for (int i = 0; i < 4; i++) begin
			pci(rc[i], ra[i], 0, r, ok);
			chk("claim", i == 3, ok);
		end
		chk("cfg0", 0, r);
		bad_par <= 1'b1;
		pci(ptlb_pkg::CMD_MEM_RD, adq[0], 0, r, ok);
		bad_par <= 1'b0;
		chk("pe_rd", mdl[adq[0]], r);
		apb(0, ptlb_pkg::OFS_ISTAT, 0, r);
		chk("pe_flag", 1, r);
		chk("irq_off", 1, pci_int_n_q);
		apb(1, ptlb_pkg::OFS_IEN, 32'h1, r);
		repeat (2) @(posedge pclk);
		chk("irq_pci", 0, pci_int_n_q);
		apb(1, ptlb_pkg::OFS_IEN, 32'h3, r);
		repeat (2) @(posedge pclk);
		chk("irq_lcl", 2, {pci_int_n_q, local_irq_out_n_q});
		apb(1, ptlb_pkg::OFS_ISTAT, 0, r);
		apb(0, ptlb_pkg::OFS_ISTAT, 0, r);
		chk("w0", 1, r);
		apb(1, ptlb_pkg::OFS_ISTAT, 1, r);
		apb(0, ptlb_pkg::OFS_ISTAT, 0, r);
		repeat (2) @(posedge pclk);
		chk("w1c", 1, {r[30:0], local_irq_out_n_q});
		apb(1, ptlb_pkg::OFS_MISC2, 32'h1, r);
		odd <= 1'b1;
		pci(ptlb_pkg::CMD_MEM_WR, 32'h1234_0900, 32'h0000_0001, r, ok);
		pci(ptlb_pkg::CMD_MEM_RD, 32'h1234_0900, 0, r, ok);
		chk("odd_rd", 1, r);
		apb(0, ptlb_pkg::OFS_ISTAT, 0, r);
		chk("odd_ok", 0, r);
		bad_par <= 1'b1;
		pci_be <= 4'hE;
		pci(ptlb_pkg::CMD_MEM_RD, 32'h4000_0900, 0, r, ok);
		bad_par <= 1'b0;
		pci_be <= 4'hF;
		apb(0, ptlb_pkg::OFS_ISTAT, 0, r);
		chk("lane_skip", 0, r);
		conclude;
	end
endmodule

bind ptlb_target_path ptlb_chk #(.WQ_WORDS(WQ_WORDS),
	.RQ_WORDS(RQ_WORDS)) u_chk (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
	.pci_req, .pci_addr, .pci_cmd, .pci_devsel_q, .pci_ack_q, .pci_int_n_q,
	.lb_req_q, .lb_wr_q, .lb_burst_q, .lb_addr_q, .lb_wdata_q,
	.local_byte_parity_q, .lb_ack, .burst_in_progress_strap,
	.size_strap_bit, .local_irq_out_n_q
);
